// ---- rtl/gia_top.sv ----
`timescale 1ns/1ps

module gia_top (
    // Clock, reset and clock enable.
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // Interrupt levels from the per-port units.
    input wire logic [gia_pkg::GIA_PORTS-1:0] framer_irq_i,
    input wire logic [gia_pkg::GIA_PORTS-1:0] tester_irq_i,
    input wire logic [gia_pkg::GIA_PORTS-1:0] line_unit_irq_i,
    // APB slave.
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [gia_pkg::GIA_ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Combined interrupt.
    output logic irq_o
);
    import gia_pkg::*;

    // Register map, as byte addresses on the bus.
    // Each register is one aligned word; only bits 7:0 carry data.
    // The printed register numbers are indices, so the byte address
    // is four times the index and the two low address bits are zero.
    // Index 0f9 holds the framer status, one bit per framer.
    // Index 0fa holds the tester status, one bit per tester.
    // Index 0fb holds the line unit status, one bit per line unit.
    // Index 0fc holds the framer enables.
    // Index 0fd holds the tester enables.
    // Index 0fe holds the line unit enables.
    // Index 0f0 holds the sticky event bits, cleared by writing ones.
    // Index 0f1 holds the event enables.
    // Any other index, or a misaligned address, is refused with an error.

    // Status behaviour.
    // The status bits are not sticky: they copy the unit levels.
    // A unit that drops its level clears its own status bit.
    // Software therefore clears a source at the unit, not here.
    // A write to a status register is accepted without error and dropped.

    // Enable behaviour.
    // A one enables a source and a zero masks it.
    // Every enable bit is zero after reset, so nothing interrupts
    // until software opens the sources that it wants.
    // A write with the low byte strobe off stores zero, by design.

    // Event behaviour.
    // Bits 0 to 2 catch the moment a group gains an enabled source.
    // Bit 3 catches a refused bus access.
    // A new event in the same cycle as its clear wins over the clear,
    // so no event can be lost between a read and the clearing write.

    // Bus timing.
    // The block answers without wait states while the clock is enabled.
    // Read data is captured in the setup cycle and shown in the access
    // cycle, so a status read shows the level seen two cycles earlier.
    // A write takes effect at the edge that ends the access cycle.

    // Clock enable.
    // While the clock enable is low, every register holds its value and
    // the bus gets no ready, so an access cycle waits; a setup cycle spent there captures no read data or error.
    // Reset acts whether or not the clock enable is high.

    // All state of the block.
    typedef struct packed {
        logic [GIA_PORTS-1:0] framer_pending_bit;
        logic [GIA_PORTS-1:0] tester_pending_bit;
        logic [GIA_PORTS-1:0] line_unit_pending_bit;
        logic [GIA_PORTS-1:0] framer_enable_bit;
        logic [GIA_PORTS-1:0] tester_enable_bit;
        logic [GIA_PORTS-1:0] line_unit_enable_bit;
        logic [2:0] group_active;
        logic [GIA_EVENTS-1:0] event_status;
        logic [GIA_EVENTS-1:0] event_enable;
        logic [31:0] rdata;
        logic slverr;
    } gia_state_t;

    gia_state_t state;
    gia_state_t next_state;

    // Maps a byte address to the register it selects; misaligned is unmapped.
    function automatic gia_sel_t gia_decode(input logic [GIA_ADDR_W-1:0] addr);
        logic [9:0] idx;
        idx = addr[GIA_ADDR_W-1:2];
        gia_decode = GIA_SEL_NONE;
        if (addr[1:0] == 2'h0) begin
            unique case (idx)
                GIA_IDX_FRAMER_STATUS: gia_decode = GIA_SEL_FRAMER_STATUS;
                GIA_IDX_TESTER_STATUS: gia_decode = GIA_SEL_TESTER_STATUS;
                GIA_IDX_LINE_STATUS: gia_decode = GIA_SEL_LINE_STATUS;
                GIA_IDX_FRAMER_ENABLE: gia_decode = GIA_SEL_FRAMER_ENABLE;
                GIA_IDX_TESTER_ENABLE: gia_decode = GIA_SEL_TESTER_ENABLE;
                GIA_IDX_LINE_ENABLE: gia_decode = GIA_SEL_LINE_ENABLE;
                GIA_IDX_EVENT_STATUS: gia_decode = GIA_SEL_EVENT_STATUS;
                GIA_IDX_EVENT_ENABLE: gia_decode = GIA_SEL_EVENT_ENABLE;
                default: gia_decode = GIA_SEL_NONE;
            endcase
        end
    endfunction

    // Bus phase and decode of the current address.
    logic setup_phase;
    logic access_phase;
    logic wr_take;
    logic [7:0] wr_byte;
    gia_sel_t sel;

    assign setup_phase = psel_i && !penable_i;
    assign access_phase = psel_i && penable_i;
    assign sel = gia_decode(paddr_i);
    assign wr_take = access_phase && pwrite_i && ce_i && (sel != GIA_SEL_NONE);
    assign wr_byte = pstrb_i[0] ? pwdata_i[7:0] : 8'h00;

    // Enabled sources per group; each group counts as active if any is pending.
    logic [2:0] group_now;
    logic [2:0] group_rise;

    assign group_now[GIA_EVT_FRAMER] =
        |(state.framer_pending_bit & state.framer_enable_bit);
    assign group_now[GIA_EVT_TESTER] =
        |(state.tester_pending_bit & state.tester_enable_bit);
    assign group_now[GIA_EVT_LINE] =
        |(state.line_unit_pending_bit & state.line_unit_enable_bit);
    assign group_rise = group_now & ~state.group_active;

    // Next-state logic for status, enables, events and read data.
    always_comb begin
        logic [GIA_EVENTS-1:0] evt_set;
        logic [GIA_EVENTS-1:0] evt_clr;
        evt_set = '0;
        evt_clr = '0;
        next_state = state;

        // Status bits follow the unit interrupt levels only.
        next_state.framer_pending_bit = framer_irq_i;
        next_state.tester_pending_bit = tester_irq_i;
        next_state.line_unit_pending_bit = line_unit_irq_i;
        next_state.group_active = group_now;

        // Events: a group gains an enabled source, or a bus access is refused.
        evt_set[2:0] = group_rise;
        evt_set[GIA_EVT_BUS_ERR] = access_phase && ce_i && (sel == GIA_SEL_NONE);

        // Register writes; status registers have no write path.
        if (wr_take) begin
            unique case (sel)
                GIA_SEL_FRAMER_ENABLE: begin
                    next_state.framer_enable_bit = wr_byte;
                end
                GIA_SEL_TESTER_ENABLE: begin
                    next_state.tester_enable_bit = wr_byte;
                end
                GIA_SEL_LINE_ENABLE: begin
                    next_state.line_unit_enable_bit = wr_byte;
                end
                GIA_SEL_EVENT_STATUS: begin
                    evt_clr = wr_byte[GIA_EVENTS-1:0];
                end
                GIA_SEL_EVENT_ENABLE: begin
                    next_state.event_enable = wr_byte[GIA_EVENTS-1:0];
                end
                default: begin
                    evt_clr = '0; // Writes to status registers are dropped.
                end
            endcase
        end

        // A new event wins over a clear in the same cycle.
        next_state.event_status = (state.event_status & ~evt_clr) | evt_set;

        // Read data and error are captured in the setup cycle.
        if (setup_phase) begin
            next_state.slverr = (sel == GIA_SEL_NONE);
            next_state.rdata = GIA_RDATA_RESET;
            if (!pwrite_i) begin
                unique case (sel)
                    GIA_SEL_FRAMER_STATUS: begin
                        next_state.rdata[7:0] = state.framer_pending_bit;
                    end
                    GIA_SEL_TESTER_STATUS: begin
                        next_state.rdata[7:0] = state.tester_pending_bit;
                    end
                    GIA_SEL_LINE_STATUS: begin
                        next_state.rdata[7:0] = state.line_unit_pending_bit;
                    end
                    GIA_SEL_FRAMER_ENABLE: begin
                        next_state.rdata[7:0] = state.framer_enable_bit;
                    end
                    GIA_SEL_TESTER_ENABLE: begin
                        next_state.rdata[7:0] = state.tester_enable_bit;
                    end
                    GIA_SEL_LINE_ENABLE: begin
                        next_state.rdata[7:0] = state.line_unit_enable_bit;
                    end
                    GIA_SEL_EVENT_STATUS: begin
                        next_state.rdata[GIA_EVENTS-1:0] = state.event_status;
                    end
                    GIA_SEL_EVENT_ENABLE: begin
                        next_state.rdata[GIA_EVENTS-1:0] = state.event_enable;
                    end
                    default: begin
                        next_state.rdata = GIA_RDATA_RESET;
                    end
                endcase
            end
        end
    end

    // Reset notes.
    // Reset is synchronous and active low.
    // It must be held for at least one rising edge.
    // Only constants are loaded, so the reset values are fixed here.
    // The read data register is cleared too, so a read right after
    // reset without a setup cycle would show zero.
    // The group history is cleared, so a source that is pending and
    // enabled after reset still raises its event bit once.

    // State register with synchronous reset; clock enable freezes all state.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state.framer_pending_bit <= GIA_STATUS_RESET;
            state.tester_pending_bit <= GIA_STATUS_RESET;
            state.line_unit_pending_bit <= GIA_STATUS_RESET;
            state.framer_enable_bit <= GIA_ENABLE_RESET;
            state.tester_enable_bit <= GIA_ENABLE_RESET;
            state.line_unit_enable_bit <= GIA_ENABLE_RESET;
            state.group_active <= 3'h0;
            state.event_status <= GIA_EVENT_RESET;
            state.event_enable <= GIA_EVENT_RESET;
            state.rdata <= GIA_RDATA_RESET;
            state.slverr <= 1'b0;
        end else if (ce_i) begin
            state <= next_state;
        end
    end

    // Output notes.
    // Ready and error are combinational and stand only in the access
    // cycle; the error flag itself was captured in the setup cycle.
    // Read data comes straight from a flip-flop and holds until the
    // next setup cycle.
    // The interrupt is a level: it stays high while any enabled source
    // is pending or any enabled event bit is set.
    // It falls one cycle after the last source drops its level, or
    // right after the write that masks the last source.
    // It is built from registered state only, so it has no glitch
    // path from the bus inputs.

    // Bus answers: zero wait states while the clock is enabled.
    assign pready_o = access_phase && ce_i;
    assign prdata_o = state.rdata;
    assign pslverr_o = access_phase && state.slverr;

    // Level interrupt: enabled unit sources or enabled sticky events.
    assign irq_o = (|group_now) | (|(state.event_status & state.event_enable));

endmodule // gia_top

// ---- include/gia_pkg.sv ----
package gia_pkg;

    // Register indices as printed; the byte address is four times the index.
    localparam logic [9:0] GIA_IDX_FRAMER_STATUS = 10'h0f9;
    localparam logic [9:0] GIA_IDX_TESTER_STATUS = 10'h0fa;
    localparam logic [9:0] GIA_IDX_LINE_STATUS = 10'h0fb;
    localparam logic [9:0] GIA_IDX_FRAMER_ENABLE = 10'h0fc;
    localparam logic [9:0] GIA_IDX_TESTER_ENABLE = 10'h0fd;
    localparam logic [9:0] GIA_IDX_LINE_ENABLE = 10'h0fe;
    localparam logic [9:0] GIA_IDX_EVENT_STATUS = 10'h0f0;
    localparam logic [9:0] GIA_IDX_EVENT_ENABLE = 10'h0f1;

    // Widths of the address bus and of the register groups.
    localparam int GIA_ADDR_W = 12;
    localparam int GIA_PORTS = 8;
    localparam int GIA_EVENTS = 4;

    // Bit positions inside the event status and event enable registers.
    localparam int GIA_EVT_FRAMER = 0;
    localparam int GIA_EVT_TESTER = 1;
    localparam int GIA_EVT_LINE = 2;
    localparam int GIA_EVT_BUS_ERR = 3;

    // Values after reset.
    localparam logic [7:0] GIA_STATUS_RESET = 8'h00;
    localparam logic [7:0] GIA_ENABLE_RESET = 8'h00;
    localparam logic [3:0] GIA_EVENT_RESET = 4'h0;
    localparam logic [31:0] GIA_RDATA_RESET = 32'h0000_0000;

    // Register selected by a bus address.
    typedef enum logic [3:0] {
        GIA_SEL_FRAMER_STATUS,
        GIA_SEL_TESTER_STATUS,
        GIA_SEL_LINE_STATUS,
        GIA_SEL_FRAMER_ENABLE,
        GIA_SEL_TESTER_ENABLE,
        GIA_SEL_LINE_ENABLE,
        GIA_SEL_EVENT_STATUS,
        GIA_SEL_EVENT_ENABLE,
        GIA_SEL_NONE
    } gia_sel_t;

endpackage

// ---- dv/gia_asserts.sv ----
`timescale 1ns/1ps
module gia_asserts (
    // Clock, reset and unit levels.
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic [7:0] framer_irq_i,
    input wire logic [7:0] tester_irq_i,
    input wire logic [7:0] line_unit_irq_i,
    // Bus and interrupt.
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    logic acc;
    logic [23:0] lvl;
    // Access phase that completes, and all unit levels side by side.
    assign acc = psel_i && penable_i && ce_i;
    assign lvl = {framer_irq_i, tester_irq_i, line_unit_irq_i};
    framer_read_a: assert property (acc && !pwrite_i && paddr_i == 12'h3e4
        |-> prdata_o[7:0] == $past(framer_irq_i, 2)) else $error("framer status wrong");
    tester_read_a: assert property (acc && !pwrite_i && paddr_i == 12'h3e8
        |-> prdata_o[7:0] == $past(tester_irq_i, 2)) else $error("tester status wrong");
    line_read_a: assert property (acc && !pwrite_i && paddr_i == 12'h3ec
        |-> prdata_o[7:0] == $past(line_unit_irq_i, 2)) else $error("line status wrong");
    status_quiet_a: assert property (acc && paddr_i inside {12'h3e4, 12'h3e8, 12'h3ec}
        |-> !pslverr_o) else $error("status access refused");
    enable_read_a: assert property (acc && !pwrite_i && paddr_i inside {12'h3f0, 12'h3f4,
        12'h3f8} |-> !pslverr_o && prdata_o[31:8] == 24'h0) else $error("enable read bad");
    reset_clear_a: assert property ($rose(rst_n_i) |-> !irq_o && prdata_o == 32'h0)
        else $error("outputs not cleared by reset");
    irq_rise_a: assert property ($rose(irq_o) |-> $past(pwrite_i && pready_o) ||
        $past(lvl) != 24'h0) else $error("interrupt rose without cause");
    irq_fall_a: assert property ($fell(irq_o) |-> $past(pwrite_i && pready_o) ||
        $past(lvl) != $past(lvl, 2)) else $error("interrupt fell without cause");
    cover property (acc && pslverr_o);
    cover property ($rose(irq_o));
    cover property (acc && pwrite_i && paddr_i == 12'h3e4);
endmodule // gia_asserts

bind gia_top gia_asserts u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .framer_irq_i(framer_irq_i), .tester_irq_i(tester_irq_i),
    .line_unit_irq_i(line_unit_irq_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .irq_o(irq_o));

// ---- dv/gia_top_tb.sv ----
`timescale 1ns/1ps
module gia_top_tb;
    import gia_pkg::*;
    typedef struct packed {
        logic [7:0] f, t, l, ef, et, el;
        logic irq;
    } gia_row_t;
    logic clk_i = 1'b0, rst_n_i = 1'b0, ce_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0;
    logic pwrite_i = 1'b0, pready_o, pslverr_o, irq_o, err;
    logic [7:0] framer_irq_i = 8'h00, tester_irq_i = 8'h00, line_unit_irq_i = 8'h00;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
    logic [3:0] pstrb_i = 4'hf;
    int n_mismatch = 0, comparisons = 0;
    // Unit levels, enables and the interrupt level they should give.
    gia_row_t rows[7] = '{'{8'h01, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 1'b1},
        '{8'h80, 8'h00, 8'h00, 8'h7f, 8'h00, 8'h00, 1'b0},
        '{8'h00, 8'h80, 8'h00, 8'h00, 8'h80, 8'h00, 1'b1},
        '{8'h00, 8'h01, 8'h00, 8'h00, 8'hfe, 8'h00, 1'b0},
        '{8'h00, 8'h00, 8'h40, 8'h00, 8'h00, 8'h40, 1'b1},
        '{8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'hfd, 1'b0},
        '{8'ha5, 8'h5a, 8'h3c, 8'h00, 8'h00, 8'h00, 1'b0}};

    gia_top dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .framer_irq_i(framer_irq_i),
        .tester_irq_i(tester_irq_i), .line_unit_irq_i(line_unit_irq_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .irq_o(irq_o));

    // Free-running 100 MHz clock.
    initial begin
        forever #5 clk_i = ~clk_i;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        if (n_mismatch == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // One bus transfer; read data and error are taken in the access cycle that completes.
    task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
        int i;
        i = 0;
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= {idx, 2'b00};
        pwdata_i <= {24'h0, wd};
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_i);
            i++;
        end while (pready_o !== 1'b1 && i < 50);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        if (i >= 50) begin
            n_mismatch++;
            results();
        end
    endtask

    // Reset, register table sweep, then the awkward cases.
    initial begin
        repeat (10) @(posedge clk_i);
        rst_n_i <= 1'b1;
        for (int j = 0; j < 6; j++) begin
            apb(1'b0, GIA_IDX_FRAMER_STATUS + 10'(j), 8'h00);
            check(rd, 32'h0);
        end
        foreach (rows[k]) begin
            apb(1'b1, GIA_IDX_FRAMER_ENABLE, rows[k].ef);
            apb(1'b1, GIA_IDX_TESTER_ENABLE, rows[k].et);
            apb(1'b1, GIA_IDX_LINE_ENABLE, rows[k].el);
            framer_irq_i <= rows[k].f;
            tester_irq_i <= rows[k].t;
            line_unit_irq_i <= rows[k].l;
            @(posedge clk_i);
            for (int j = 0; j < 6; j++) begin
                apb(1'b0, GIA_IDX_FRAMER_STATUS + 10'(j), 8'h00);
                check(rd, {24'h0, rows[k][48-8*j -: 8]});
            end
            check(irq_o, rows[k].irq);
        end
        apb(1'b1, GIA_IDX_FRAMER_STATUS, 8'h00);
        apb(1'b0, GIA_IDX_FRAMER_STATUS, 8'h00);
        check({err, rd}, {1'b0, 32'h0000_00a5});
        apb(1'b0, 10'h0ff, 8'h00);
        check({err, rd}, {1'b1, 32'h0});
        apb(1'b1, GIA_IDX_FRAMER_ENABLE, 8'h80);
        @(posedge clk_i);
        check(irq_o, 1'b1);
        framer_irq_i <= 8'h25;
        repeat (3) @(posedge clk_i);
        check(irq_o, 1'b0);
        ce_i <= 1'b0;
        framer_irq_i <= 8'h80;
        repeat (3) @(posedge clk_i);
        check(irq_o, 1'b0);
        ce_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        check(irq_o, 1'b1);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        apb(1'b0, GIA_IDX_FRAMER_ENABLE, 8'h00);
        check(rd, 32'h0);
        check(irq_o, 1'b0);
        apb(1'b1, GIA_IDX_EVENT_ENABLE, 8'h08);
        apb(1'b0, 10'h0ff, 8'h00);
        @(posedge clk_i);
        check(irq_o, 1'b1);
        apb(1'b1, GIA_IDX_EVENT_STATUS, 8'h08);
        @(posedge clk_i);
        check(irq_o, 1'b0);
        results();
    end
endmodule // gia_top_tb
